/* ipg_pkg.sv */
// constants, types and register map of the interrupt positioning pulse block
//
// Overview of operation
// - relative pulse count is nonzero, 16-bit form or +-999,999 in 32-bit form
// - frequency 10..32,767 Hz; 32-bit: 200,000 adapter, 100,000 transistor
// - each instruction drives exactly one pulse channel 0 to 3
// - positive count: direction high, position up; negative: low, down
// - selection disabled: channels 0..3 trigger on inputs 0..3
// - selection enabled: code 0..7 picks trigger input 0..7
// - code 8 picks that channel's own software trigger command bit
// - codes 9..E at activation give error 6763 and no pulses
// - after the trigger, output the programmed count then stop
// - channel 3 only usable with a second output adapter fitted
// - invert bit off: active input triggers; on: inactive input triggers
// - when the post-trigger count is done, set the complete flag
package ipg_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int ADDR_W = 5;
	localparam int SYNC_W = 9;

	////////////////////////////////////////////////////////////////////////
	localparam logic [4:0] OFF_CTRL   = 5'h00;
	localparam logic [4:0] OFF_SELECT = 5'h04;
	localparam logic [4:0] OFF_COUNT  = 5'h08;
	localparam logic [4:0] OFF_FREQ   = 5'h0C;
	localparam logic [4:0] OFF_STATUS = 5'h10;
	localparam logic [4:0] OFF_POS    = 5'h14;
	localparam logic [4:0] OFF_IRQ    = 5'h18;
	localparam logic [4:0] OFF_MASK   = 5'h1C;

	localparam int CB_START = 0;
	localparam int CB_WIDE  = 1;
	localparam int CB_ADPT  = 2;
	localparam int CB_CH    = 4;
	localparam int CB_SELEN = 6;
	localparam int CB_INV   = 8;
	localparam int CB_USR   = 12;

	localparam int SB_BUSY  = 0;
	localparam int SB_DONE  = 1;
	localparam int SB_ERR   = 2;
	localparam int SB_TRIG  = 3;
	localparam int SB_CODE  = 16;

	localparam int IB_DONE  = 0;
	localparam int IB_ERR   = 1;
	localparam int IB_TRIG  = 2;

	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam logic [15:0] SELECT_RST = 16'hFFFF;
	localparam logic [31:0] COUNT_RST  = 32'h0000_0000;
	localparam logic [31:0] FREQ_RST   = 32'h0000_0000;
	localparam logic [2:0]  MASK_RST   = 3'h0;

	////////////////////////////////////////////////////////////////////////
	localparam int          CNT32_LIM     = 999_999;
	localparam logic [31:0] FREQ_MIN      = 32'h0000_000A;
	localparam logic [31:0] FREQ16_MAX    = 32'h0000_7FFF;
	localparam logic [31:0] FREQ_ADPT_MAX = 32'h0003_0D40;
	localparam logic [31:0] FREQ_TR_MAX   = 32'h0001_86A0;

	localparam logic [3:0]  SEL_USER   = 4'h8;
	localparam logic [3:0]  SEL_ERR_LO = 4'h9;
	localparam logic [3:0]  SEL_ERR_HI = 4'hE;
	localparam logic [3:0]  SEL_UNUSED = 4'hF;
	localparam logic [15:0] ERR_CODE   = 16'h1A6B;

	typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_POST} ipg_state_e;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [31:0]       wdata;
	} ipg_bus_s;
endpackage

/* ipg_in_sync.sv */
// three-stage input synchroniser that accepts a level once stages agree
`timescale 1ns/100ps
`default_nettype none
module ipg_in_sync #(
	parameter int WIDTH = 9
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// asynchronous levels in, filtered levels out
	input  wire logic [WIDTH-1:0] din,
	output var  logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] dout_reg;
	logic [WIDTH-1:0] agree;
	logic [WIDTH-1:0] dout_next;

	// s1 feeds only s2; the compare looks at stages two and three
	assign agree     = ~(s2_reg ^ s3_reg);
	assign dout_next = (s3_reg & agree) | (dout_reg & ~agree);
	assign dout      = dout_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			dout_reg <= '0;
		end else begin
			s1_reg   <= din;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			dout_reg <= dout_next;
		end
	end
endmodule // ipg_in_sync
`default_nettype wire

/* ipg_rate_gen.sv */
// phase accumulator giving two enable ticks per output pulse period
`timescale 1ns/100ps
`default_nettype none
module ipg_rate_gen #(
	parameter int CLK_HZ = ipg_pkg::CLK_HZ
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// control
	input  wire logic        enable,
	input  wire logic [31:0] freqHz,
	// one-cycle tick at twice freqHz
	output var  logic        tick
);
	localparam logic [32:0] LIMIT = 33'(CLK_HZ);

	logic [31:0] acc_reg;
	logic [31:0] acc_next;
	logic [32:0] sum;
	logic        wrap;
	logic        tick_reg;

	// no divider: the error of each period is at most one clock
	assign sum      = {1'b0, acc_reg} + {1'b0, freqHz[30:0], 1'b0};
	assign wrap     = enable && (sum >= LIMIT);
	assign acc_next = !enable ? 32'h0000_0000 :
	                  wrap ? 32'(sum - LIMIT) : sum[31:0];
	assign tick     = tick_reg;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg  <= 32'h0000_0000;
			tick_reg <= 1'b0;
		end else begin
			acc_reg  <= acc_next;
			tick_reg <= wrap;
		end
	end
endmodule // ipg_rate_gen
`default_nettype wire

/* ipg_top.sv */
// interrupt positioning pulse generator with register port and interrupt
`timescale 1ns/100ps
`default_nettype none
module ipg_top #(
	parameter int CLK_HZ = ipg_pkg::CLK_HZ
) (
	// clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// register port
	input  wire ipg_pkg::ipg_bus_s bus,
	output var  logic [31:0]      rdData,
	// controller mode, low clears the control bits
	input  wire logic             plcRun,
	// pins
	input  wire logic [7:0]       trigIn,
	input  wire logic             adapter2Fitted,
	// drive side
	output var  logic [3:0]       pulseOut,
	output var  logic [3:0]       directionOut,
	output var  logic             completeFlag,
	output var  logic             irq
);
	import ipg_pkg::*;

	////////////////////////////////////////////////////////////////////////
	logic [15:0] ctrl_reg;
	logic [15:0] select_reg;
	logic [31:0] count_reg;
	logic [31:0] freq_reg;
	logic [2:0]  irqStat_reg;
	logic [2:0]  irqMask_reg;
	logic [31:0] rdData_reg;
	logic        startPrev_reg;
	ipg_state_e  state_reg;
	ipg_state_e  state_next;
	logic [1:0]  ch_reg;
	logic        neg_reg;
	logic [31:0] remain_reg;
	logic [31:0] remain_next;
	logic [31:0] runFreq_reg;
	logic [31:0] pos_reg;
	logic [31:0] pos_next;
	logic [3:0]  pulse_reg;
	logic [3:0]  pulse_next;
	logic [3:0]  dir_reg;
	logic        done_reg;
	logic        done_next;
	logic        err_reg;
	logic        err_next;
	logic        evDone;
	logic        evErr;
	logic        evTrig;
	logic        tick;
	logic [8:0]  syncIn;

	ipg_in_sync #(.WIDTH(SYNC_W)) u_sync (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.din     ({adapter2Fitted, trigIn}),
		.dout    (syncIn)
	);

	wire running = (state_reg != ST_IDLE);

	ipg_rate_gen #(.CLK_HZ(CLK_HZ)) u_rate (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.enable  (running),
		.freqHz  (runFreq_reg),
		.tick    (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// register decode
	wire wrCtrl  = bus.wr && (bus.addr == OFF_CTRL);
	wire wrSel   = bus.wr && (bus.addr == OFF_SELECT);
	wire wrCount = bus.wr && (bus.addr == OFF_COUNT);
	wire wrFreq  = bus.wr && (bus.addr == OFF_FREQ);
	wire wrMask  = bus.wr && (bus.addr == OFF_MASK);
	wire rdIrq   = bus.rd && (bus.addr == OFF_IRQ);

	wire [15:0] ctrl_next = !plcRun ? CTRL_RST :
	                        wrCtrl ? bus.wdata[15:0] : ctrl_reg;

	wire       startBit = ctrl_reg[CB_START];
	wire       wide     = ctrl_reg[CB_WIDE];
	wire       adptOut  = ctrl_reg[CB_ADPT];
	wire [1:0] chSel    = ctrl_reg[CB_CH +: 2];
	wire       selEn    = ctrl_reg[CB_SELEN];
	wire [3:0] invBits  = ctrl_reg[CB_INV +: 4];
	wire [3:0] usrCmd   = ctrl_reg[CB_USR +: 4];
	wire       activate = startBit && !startPrev_reg;

	////////////////////////////////////////////////////////////////////////
	// operand checks made once, at activation
	wire [31:0] cntEff = wide ? count_reg :
	                     {{16{count_reg[15]}}, count_reg[15:0]};
	wire        cntNeg = cntEff[31];
	wire [31:0] cntMag = cntNeg ? 32'(-cntEff) : cntEff;
	wire        cntOk  = (cntEff != 32'h0000_0000) && (!wide ||
	                     ($signed(cntEff) >= -CNT32_LIM &&
	                      $signed(cntEff) <= CNT32_LIM));
	wire [31:0] freqEff = wide ? freq_reg : {16'h0000, freq_reg[15:0]};
	wire [31:0] freqMax = !wide ? FREQ16_MAX :
	                      adptOut ? FREQ_ADPT_MAX : FREQ_TR_MAX;
	wire        freqOk  = (freqEff >= FREQ_MIN) &&
	                      (freqEff <= freqMax);
	wire [3:0]  selNew  = select_reg[4*chSel +: 4];
	// code F has no trigger source, so it is refused like 9..E
	wire        selBad  = selEn && (selNew >= SEL_ERR_LO);
	wire        chBad   = (chSel == 2'h3) && !syncIn[8];
	wire        opBad   = !cntOk || !freqOk || selBad || chBad;

	////////////////////////////////////////////////////////////////////////
	// trigger source of the running channel
	wire [3:0] selRun  = select_reg[4*ch_reg +: 4];
	wire [2:0] physIdx = selEn ? selRun[2:0] : {1'b0, ch_reg};
	wire       physLvl = syncIn[physIdx] ^ invBits[ch_reg];
	// the software command ignores the invert bit
	wire       trigLvl = (selEn && selRun == SEL_USER) ?
	                     usrCmd[ch_reg] : physLvl;
	wire [2:0] physNew = selEn ? selNew[2:0] : {1'b0, chSel};
	wire       trigNew = (selEn && selNew == SEL_USER) ?
	                     usrCmd[chSel] : (syncIn[physNew] ^ invBits[chSel]);

	wire lvl     = |pulse_reg;
	wire riseNow = running && tick && !lvl;
	wire fallNow = running && tick && lvl;

	always_comb begin
		state_next  = state_reg;
		remain_next = remain_reg;
		pos_next    = pos_reg;
		pulse_next  = pulse_reg;
		done_next   = done_reg;
		err_next    = err_reg;
		evDone      = 1'b0;
		evErr       = 1'b0;
		evTrig      = 1'b0;
		if (riseNow) begin
			pulse_next = 4'h1 << ch_reg;
			pos_next   = neg_reg ? pos_reg - 32'h1 : pos_reg + 32'h1;
		end
		if (fallNow) begin
			pulse_next = 4'h0;
		end
		case (state_reg)
		ST_IDLE: begin
			pulse_next = 4'h0;
			if (activate) begin
				done_next = 1'b0;
				err_next  = opBad;
				evErr     = opBad;
				if (!opBad) begin
					remain_next = cntMag;
					// an already active trigger counts at once
					state_next  = trigNew ? ST_POST : ST_PRE;
					evTrig      = trigNew;
				end
			end
		end
		ST_PRE: begin
			if (!startBit) begin
				state_next = ST_IDLE;
				pulse_next = 4'h0;
				// a rise cut off by the stop never reaches the drive
				pos_next   = pos_reg;
			end else if (trigLvl) begin
				state_next = ST_POST;
				evTrig     = 1'b1;
			end
		end
		ST_POST: begin
			if (!startBit) begin
				state_next = ST_IDLE;
				pulse_next = 4'h0;
				pos_next   = pos_reg;
			end else begin
				if (riseNow) begin
					remain_next = remain_reg - 32'h1;
				end
				if (fallNow && remain_reg == 32'h0000_0000) begin
					state_next = ST_IDLE;
					done_next  = 1'b1;
					evDone     = 1'b1;
				end
			end
		end
		default: begin
			state_next = ST_IDLE;
			pulse_next = 4'h0;
			pos_next   = pos_reg;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// status, interrupt and read data
	wire [2:0] events = {evTrig, evErr, evDone};
	// an event in the cycle of the clearing read survives it
	wire [2:0] irqStat_next = (irqStat_reg & ~{3{rdIrq}}) | events;
	wire [31:0] statusWord = {(err_reg ? ERR_CODE : 16'h0000), 12'h000,
	                          state_reg == ST_POST, err_reg, done_reg,
	                          running};
	wire [31:0] rdMux =
		(bus.addr == OFF_CTRL)   ? {16'h0000, ctrl_reg} :
		(bus.addr == OFF_SELECT) ? {16'h0000, select_reg} :
		(bus.addr == OFF_COUNT)  ? count_reg :
		(bus.addr == OFF_FREQ)   ? freq_reg :
		(bus.addr == OFF_STATUS) ? statusWord :
		(bus.addr == OFF_POS)    ? pos_reg :
		(bus.addr == OFF_IRQ)    ? {29'h0, irqStat_reg} :
		(bus.addr == OFF_MASK)   ? {29'h0, irqMask_reg} : 32'h0000_0000;

	assign rdData       = rdData_reg;
	assign pulseOut     = pulse_reg;
	assign directionOut = dir_reg;
	assign completeFlag = done_reg;
	assign irq          = |(irqStat_reg & irqMask_reg);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg      <= CTRL_RST;
			select_reg    <= SELECT_RST;
			count_reg     <= COUNT_RST;
			freq_reg      <= FREQ_RST;
			irqMask_reg   <= MASK_RST;
			irqStat_reg   <= 3'h0;
			rdData_reg    <= 32'h0000_0000;
			startPrev_reg <= 1'b0;
		end else begin
			ctrl_reg      <= ctrl_next;
			select_reg    <= wrSel ? bus.wdata[15:0] : select_reg;
			count_reg     <= wrCount ? bus.wdata : count_reg;
			freq_reg      <= wrFreq ? bus.wdata : freq_reg;
			irqMask_reg   <= wrMask ? bus.wdata[2:0] : irqMask_reg;
			irqStat_reg   <= irqStat_next;
			rdData_reg    <= bus.rd ? rdMux : 32'h0000_0000;
			startPrev_reg <= startBit;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg   <= ST_IDLE;
			remain_reg  <= 32'h0000_0000;
			pos_reg     <= 32'h0000_0000;
			pulse_reg   <= 4'h0;
			done_reg    <= 1'b0;
			err_reg     <= 1'b0;
			ch_reg      <= 2'h0;
			neg_reg     <= 1'b0;
			runFreq_reg <= 32'h0000_0000;
			dir_reg     <= 4'h0;
		end else begin
			state_reg  <= state_next;
			remain_reg <= remain_next;
			pos_reg    <= pos_next;
			pulse_reg  <= pulse_next;
			done_reg   <= done_next;
			err_reg    <= err_next;
			// operands are frozen until the next activation
			if (state_reg == ST_IDLE && activate && !opBad) begin
				ch_reg           <= chSel;
				neg_reg          <= cntNeg;
				runFreq_reg      <= freqEff;
				dir_reg[chSel]   <= !cntNeg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	property p_oneChannel;
		@(posedge sys_clk) disable iff (!rst_n) $onehot0(pulse_reg);
	endproperty
	a_oneChannel: assert property (p_oneChannel)
		else $error("more than one pulse channel active");

	property p_dirSet;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_IDLE && activate && !opBad)
		|=> dir_reg[ch_reg] == !neg_reg && neg_reg == $past(cntNeg);
	endproperty
	a_dirSet: assert property (p_dirSet)
		else $error("direction does not follow count sign");

	property p_posStep;
		@(posedge sys_clk) disable iff (!rst_n)
		$rose(lvl) |-> pos_reg == (neg_reg ? $past(pos_reg) - 32'h1
		                                   : $past(pos_reg) + 32'h1);
	endproperty
	a_posStep: assert property (p_posStep)
		else $error("position not stepped on pulse");

	property p_badSel;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_IDLE && activate && selEn &&
		 selNew >= SEL_ERR_LO && selNew <= SEL_ERR_HI)
		|=> err_reg && state_reg == ST_IDLE ##1 pulse_reg == 4'h0;
	endproperty
	a_badSel: assert property (p_badSel)
		else $error("bad selection code not refused");

	property p_ch3;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_IDLE && activate && chSel == 2'h3 && !syncIn[8])
		|=> err_reg && !running;
	endproperty
	a_ch3: assert property (p_ch3)
		else $error("channel 3 started without second adapter");

	property p_zeroCount;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_IDLE && activate && cntEff == 32'h0000_0000)
		|=> err_reg;
	endproperty
	a_zeroCount: assert property (p_zeroCount)
		else $error("zero count accepted");

	property p_lowFreq;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_IDLE && activate && freqEff < FREQ_MIN) |=> err_reg;
	endproperty
	a_lowFreq: assert property (p_lowFreq)
		else $error("frequency below minimum accepted");

	property p_preHold;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_PRE) |=> remain_reg == $past(remain_reg);
	endproperty
	a_preHold: assert property (p_preHold)
		else $error("count moved before trigger");

	property p_finish;
		@(posedge sys_clk) disable iff (!rst_n)
		(state_reg == ST_POST && startBit && fallNow &&
		 remain_reg == 32'h0000_0000)
		|=> done_reg && !running ##1 pulse_reg == 4'h0;
	endproperty
	a_finish: assert property (p_finish)
		else $error("run did not end with complete flag");

	c_trigger: cover property (@(posedge sys_clk) disable iff (!rst_n)
		state_reg == ST_PRE ##1 state_reg == ST_POST);
	c_done: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(done_reg));
	c_error: cover property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(err_reg));
endmodule // ipg_top
`default_nettype wire

/* ipg_drive_model.sv */
// drive-side model: takes step and direction, tracks position per axis
`timescale 1ns/100ps
`default_nettype none
module ipg_drive_model (
	// clock used only to sample the step and direction lines
	input  wire logic               sys_clk,
	// step and direction from the generator, never driven here
	input  wire logic [3:0]         pulseOut,
	input  wire logic [3:0]         directionOut,
	// observed motion
	output var  logic signed [31:0] pos [4],
	output var  int                 edges
);
	logic [3:0] pulseLast;

	initial begin
		pulseLast = 4'h0;
		edges = 0;
		for (int i = 0; i < 4; i++) begin
			pos[i] = 32'sh0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// each axis reads only its own direction line, latched at the step edge
	always @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (pulseOut[i] === 1'b1 && pulseLast[i] === 1'b0) begin
				pos[i] <= directionOut[i] ? pos[i] + 1 : pos[i] - 1;
			end
		end
		// every step on any axis counts, to catch stray pulses
		edges <= edges + $countones(pulseOut & ~pulseLast);
		pulseLast <= pulseOut;
	end
endmodule // ipg_drive_model
`default_nettype wire

/* ipg_top_tb.sv */
// self-checking bench for the interrupt positioning pulse generator
`timescale 1ns/100ps
`default_nettype none
module ipg_top_tb;
	import ipg_pkg::*;
	typedef struct packed {logic [31:0] d; logic [31:0] m;} ipg_exp_s;
	logic               sys_clk, rst_n, plcRun, adapter2Fitted;
	logic               completeFlag, irq, rdPend;
	logic [7:0]         trigIn;
	logic [31:0]        rdData;
	logic [3:0]         pulseOut, directionOut;
	logic signed [31:0] pos [4];
	ipg_bus_s           bus;
	ipg_exp_s           expQ[$];
	ipg_exp_s           expHead;
	int                 edges, miscompares, num_checks, cycles, e0;

	// slow clock constant keeps a 100 Hz pulse at ten cycles per period
	ipg_top #(.CLK_HZ(1000)) ipg_top_inst (.sys_clk(sys_clk), .rst_n(rst_n),
		.bus(bus), .rdData(rdData), .plcRun(plcRun), .trigIn(trigIn),
		.adapter2Fitted(adapter2Fitted), .pulseOut(pulseOut),
		.directionOut(directionOut), .completeFlag(completeFlag), .irq(irq));
	ipg_drive_model ipg_drive_model_inst (.sys_clk(sys_clk),
		.pulseOut(pulseOut), .directionOut(directionOut), .pos(pos),
		.edges(edges));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge sys_clk);
		bus.wr <= 1'b0;
	endtask

	// the expectation is queued; the monitor below compares it
	task automatic rd(input logic [4:0] a, input logic [31:0] d,
		input logic [31:0] m);
		expQ.push_back('{d: d & m, m: m});
		@(posedge sys_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge sys_clk);
		bus.rd <= 1'b0;
	endtask

	always @(posedge sys_clk) begin
		if (rdPend) begin
			expHead = expQ.pop_front();
			chk(rdData & expHead.m, expHead.d, "read data");
		end
		rdPend <= bus.rd;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			summarize();
		end
	end

	function automatic logic [31:0] rndCnt();
		logic [31:0] v;
		v = 32'(1 + $urandom % 4);
		return ($urandom % 2) ? -v : v;
	endfunction

	// one activation; tp is the trigger pin (-1 for the software command)
	task automatic runOp(input logic [1:0] ch, input logic [15:0] ctrlX,
		input logic [15:0] sel, input logic [31:0] cnt, input logic [31:0] frq,
		input int tp, input logic err, input logic pre);
		logic signed [31:0] p0;
		logic [31:0]        mag;
		int                 e1, k;
		mag = cnt[31] ? -cnt : cnt;
		if (tp >= 0) trigIn[tp] <= ctrlX[CB_INV + 32'(ch)] ^ ~pre;
		wr(OFF_SELECT, {16'h0, sel});
		wr(OFF_COUNT, cnt);
		wr(OFF_FREQ, frq);
		idle(4);
		p0 = pos[ch];
		e1 = edges;
		wr(OFF_CTRL, {16'h0, ctrlX | {10'h0, ch, 4'h1}});
		if (err) begin
			idle(10);
			rd(OFF_STATUS, {ERR_CODE, 16'h0004}, 32'hFFFF_0004);
			chk(32'(edges - e1), 32'h0, "pulses on refused start");
		end else begin
			idle(2);
			chk(32'(completeFlag), 32'h0, "complete at start");
			if (pre) begin
				idle(80);
				chk(32'(edges - e1 > 3), 32'h1, "steps before trigger");
				chk(32'(completeFlag), 32'h0, "early complete");
				rd(OFF_STATUS, 32'h0000_0001, 32'hFFFF_000F);
				trigIn[tp] <= ~trigIn[tp];
			end
			k = 0;
			while (completeFlag !== 1'b1 && k < 3000) begin
				@(posedge sys_clk);
				k++;
			end
			idle(20);
			chk(32'(completeFlag), 32'h1, "complete flag");
			rd(OFF_STATUS, 32'h0000_0002, 32'hFFFF_000F);
			chk(32'(directionOut[ch]), {31'h0, ~cnt[31]}, "direction");
			if (!pre) begin
				chk(pos[ch] - p0, cnt, "signed travel");
				chk(32'(edges - e1), mag, "steps on all axes");
			end
		end
		chk(32'(irq), 32'h1, "irq level");
		rd(OFF_IRQ, err ? 32'h2 : 32'h5, 32'h7);
		idle(2);
		chk(32'(irq), 32'h0, "irq after clear");
		wr(OFF_CTRL, 32'h0);
		trigIn <= 8'h0;
		idle(2);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		bus = '0;
		rdPend = 1'b0;
		plcRun = 1'b1;
		trigIn = 8'h0;
		adapter2Fitted = 1'b0;
		rst_n = 1'b0;
		void'($urandom(83166));
		idle(16);
		rst_n <= 1'b1;
		idle(2);
		rd(OFF_CTRL, 32'h0, 32'hFFFF_FFFF);
		rd(OFF_SELECT, 32'h0000_FFFF, 32'hFFFF_FFFF);
		rd(OFF_MASK, 32'h0, 32'hFFFF_FFFF);
		rd(5'h02, 32'h0, 32'hFFFF_FFFF);
		wr(OFF_MASK, 32'h7);
		rd(OFF_MASK, 32'h7, 32'hFFFF_FFFF);
		$display("test registers done");
		for (int c = 0; c < 3; c++) runOp(2'(c), 16'h0, 16'hFFFF, rndCnt(), 100, c, 0, 0);
		$display("test fixed trigger pins done");
		for (int s = 0; s < 8; s++) runOp(2'd2, 16'h0040, {4'hF, 4'(s), 8'hFF}, rndCnt(), 100, s, 0, 0);
		$display("test selected trigger pins done");
		adapter2Fitted <= 1'b1;
		idle(4);
		for (int c = 0; c < 4; c++) runOp(2'(c), 16'h0040 | (16'h1000 << c), 16'hFFFF & ~(16'h0007 << (4 * c)), rndCnt(), 100, -1, 0, 0);
		$display("test software trigger done");
		runOp(2'd1, 16'h0200, 16'hFFFF, -32'sd3, 100, 1, 0, 0);
		runOp(2'd0, 16'h0, 16'hFFFF, 32'd3, 100, 0, 0, 1);
		runOp(2'd0, 16'h0006, 16'hFFFF, -32'sd2, 32'd150000, 0, 0, 0);
		$display("test inverted and late trigger done");
		for (int c = 9; c < 16; c++) runOp(2'd1, 16'h0040, {8'hFF, 4'(c), 4'hF}, 32'd2, 100, -1, 1, 0);
		runOp(2'd0, 16'h0, 16'hFFFF, 32'd0, 100, 0, 1, 0);
		runOp(2'd0, 16'h0002, 16'hFFFF, 32'd1_000_000, 100, 0, 1, 0);
		runOp(2'd0, 16'h0, 16'hFFFF, 32'd3, 32'd9, 0, 1, 0);
		runOp(2'd0, 16'h0, 16'hFFFF, 32'd3, 32'd32768, 0, 1, 0);
		runOp(2'd0, 16'h0002, 16'hFFFF, 32'd3, 32'd100001, 0, 1, 0);
		runOp(2'd0, 16'h0006, 16'hFFFF, 32'd3, 32'd200001, 0, 1, 0);
		adapter2Fitted <= 1'b0;
		idle(4);
		runOp(2'd3, 16'h0, 16'hFFFF, 32'd2, 100, 3, 1, 0);
		$display("test refusals done");
		wr(OFF_COUNT, 32'd5);
		wr(OFF_FREQ, 32'd100);
		wr(OFF_CTRL, 32'h1);
		idle(40);
		plcRun <= 1'b0;
		idle(1);
		plcRun <= 1'b1;
		idle(4);
		e0 = edges;
		idle(40);
		chk(32'(edges - e0), 32'h0, "steps after stop");
		chk(32'(completeFlag), 32'h0, "complete after stop");
		rd(OFF_CTRL, 32'h0, 32'hFFFF_FFFF);
		rd(OFF_STATUS, 32'h0, 32'hFFFF_000F);
		rd(OFF_IRQ, 32'h0, 32'h7);
		rd(OFF_POS, pos[0] + pos[1] + pos[2] + pos[3], 32'hFFFF_FFFF);
		idle(2);
		$display("test stop by mode change done");
		summarize();
	end
endmodule // ipg_top_tb
`default_nettype wire
